// [src/mse_pkg.sv]
// Purpose: Shared constants for the multiply/subtract execution block
// Assumes: APB slave with 32-bit data, byte addresses
// Notes:   Opcode patterns, field positions, register map, reset values
package mse_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_INSTR   = 8'h00;
    localparam logic [7:0] OFF_ACC     = 8'h04;
    localparam logic [7:0] OFF_BANKSEL = 8'h08;
    localparam logic [7:0] OFF_PROD    = 8'h0C;
    localparam logic [7:0] OFF_FLAGS   = 8'h10;
    localparam logic [7:0] OFF_MADDR   = 8'h14;
    localparam logic [7:0] OFF_MDATA   = 8'h18;

    // Opcode patterns
    localparam logic [7:0] OPC_MUL_LIT = 8'h0D;
    localparam logic [7:0] OPC_SUB_LIT = 8'h08;
    localparam logic [6:0] OPC_MUL_REG = 7'h01;
    localparam logic [5:0] OPC_SUB_REG = 6'h17;

    // Instruction field positions
    localparam int BIT_ACCESS = 8;
    localparam int BIT_DEST   = 9;

    // Status register read fields
    localparam int BIT_BUSY   = 16;
    localparam int BIT_BAD    = 17;

    // Flag bit positions
    localparam int FLG_C           = 0;
    localparam int FLG_DIGIT_CARRY = 1;
    localparam int FLG_Z           = 2;
    localparam int FLG_OVERFLOW    = 3;
    localparam int FLG_N           = 4;

    // Access bank split and high bank
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HIGH  = 4'hF;
    localparam logic [3:0] ACCESS_LOW   = 4'h0;

    // Reset values
    localparam logic [7:0]  RST_ACC   = 8'h00;
    localparam logic [3:0]  RST_BANK  = 4'h0;
    localparam logic [15:0] RST_PROD  = 16'h0000;
    localparam logic [4:0]  RST_FLAGS = 5'h00;

    // Data memory depth: 16 banks of 256 bytes
    localparam int MEM_DEPTH = 4096;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } mse_phase_type;

    typedef enum logic [2:0] {
        K_NONE,
        K_MUL_LIT,
        K_MUL_REG,
        K_SUB_LIT,
        K_SUB_REG
    } mse_kind_type;
endpackage

// [src/mse_alu.sv]
// Purpose: Combinational multiply and subtract with flag generation
// Assumes: Unsigned 8x8 product, two's complement difference
// Notes:   Difference is minuend minus subtrahend
`timescale 1ns/10ps
module mse_alu (
    // Operation select
    input  wire logic        do_sub,
    // Operands
    input  wire logic [7:0]  minuend,
    input  wire logic [7:0]  subtrahend,
    // Results
    output logic      [15:0] result,
    output logic      [4:0]  flags
);
    logic [8:0] full_sum;
    logic [4:0] nib_sum;

    // Add of inverted subtrahend plus one gives borrow-free carry
    always_comb begin
        full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
        nib_sum  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
        flags    = 5'h00;
        if (do_sub) begin
            result = {8'h00, full_sum[7:0]};
            flags[mse_pkg::FLG_C]  = full_sum[8];
            flags[mse_pkg::FLG_DIGIT_CARRY] = nib_sum[4];
            flags[mse_pkg::FLG_Z]  = (full_sum[7:0] == 8'h00);
            flags[mse_pkg::FLG_OVERFLOW] = (minuend[7] != subtrahend[7]) && (full_sum[7] != minuend[7]);
            flags[mse_pkg::FLG_N]  = full_sum[7];
        end else begin
            result = 16'(minuend) * 16'(subtrahend);
        end
    end
endmodule

// [src/mse_exec.sv]
// Purpose: Four-phase execution of multiply and subtract instructions
// Assumes: Software issues instruction words over APB, one at a time
// Notes:   Data memory is 16 banks of 256 bytes reached through a window
//          APB answers after one wait state; busy stands four cycles, one cycle for an unknown opcode
`timescale 1ns/10ps
module mse_exec (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Execution state
    output logic             busy
);
    // All block state but the data memory in one record, registered each clock
    typedef struct packed {
        // Execution pipeline
        mse_pkg::mse_phase_type phase;
        mse_pkg::mse_kind_type  kind;
        logic [15:0]            instr;
        logic [11:0]            eaddr;
        logic [7:0]             operand;
        logic [15:0]            result;
        logic [4:0]             new_flags;
        // Software-visible registers
        logic [7:0]             acc;
        logic [3:0]             bank;
        logic [15:0]            prod;
        logic [4:0]             flags;
        logic [11:0]            maddr;
        logic                   bad;
        logic                   busy;
        // Bus answer
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
    } mse_state_type;

    mse_state_type q;
    mse_state_type d;

    // Data memory and its write port
    logic [7:0]  mem [0:mse_pkg::MEM_DEPTH-1];
    logic        mem_we;
    logic [11:0] mem_wa;
    logic [7:0]  mem_wd;
    logic [7:0]  mem_rd_ea;
    logic [7:0]  mem_rd_sw;
    logic [15:0] alu_result;
    logic [4:0]  alu_flags;
    logic        is_sub;
    logic        xfer;
    logic        idle;

    // Operand address from access bit, bank select and file field
    function automatic logic [11:0] resolve_addr(input logic [15:0] ins, input logic [3:0] bank);
        logic [7:0] f;
        f = ins[7:0];
        if (!ins[mse_pkg::BIT_ACCESS]) begin
            resolve_addr = (f < mse_pkg::ACCESS_SPLIT) ? {mse_pkg::ACCESS_LOW, f} : {mse_pkg::ACCESS_HIGH, f};
        end else begin
            resolve_addr = {bank, f};
        end
    endfunction

    // Register write refused while an instruction runs
    function automatic logic refuse_wr(input logic wr, input mse_pkg::mse_phase_type ph);
        refuse_wr = wr && (ph != mse_pkg::PH_IDLE);
    endfunction

    // Opcode classification
    function automatic mse_pkg::mse_kind_type decode(input logic [15:0] ins);
        decode = mse_pkg::K_NONE;
        if (ins[15:8] == mse_pkg::OPC_MUL_LIT) begin
            decode = mse_pkg::K_MUL_LIT;
        end else if (ins[15:8] == mse_pkg::OPC_SUB_LIT) begin
            decode = mse_pkg::K_SUB_LIT;
        end else if (ins[15:9] == mse_pkg::OPC_MUL_REG) begin
            decode = mse_pkg::K_MUL_REG;
        end else if (ins[15:10] == mse_pkg::OPC_SUB_REG) begin
            decode = mse_pkg::K_SUB_REG;
        end
    endfunction

    // Arithmetic unit
    mse_alu u_alu (
        .do_sub     (is_sub),
        .minuend    (q.operand),
        .subtrahend (q.acc),
        .result     (alu_result),
        .flags      (alu_flags)
    );

    // Memory read ports
    assign mem_rd_ea = mem[q.eaddr];
    assign mem_rd_sw = mem[q.maddr];

    // Decode helpers
    assign is_sub    = (q.kind == mse_pkg::K_SUB_LIT) || (q.kind == mse_pkg::K_SUB_REG);
    assign idle      = (q.phase == mse_pkg::PH_IDLE);
    assign xfer      = psel && penable && q.pready;

    // Next-state logic
    always_comb begin
        d         = q;
        d.pready  = 1'b0;
        mem_we    = 1'b0;
        mem_wa    = q.eaddr;
        mem_wd    = q.result[7:0];

        unique case (q.phase)
            mse_pkg::PH_IDLE: begin
                // Nothing runs until an instruction word lands
            end
            mse_pkg::PH_Q1: begin
                // Unknown opcode returns to idle with bad set
                d.kind  = decode(q.instr);
                d.eaddr = resolve_addr(q.instr, q.bank);
                d.phase = (decode(q.instr) == mse_pkg::K_NONE) ? mse_pkg::PH_IDLE : mse_pkg::PH_Q2;
                d.bad   = (decode(q.instr) == mse_pkg::K_NONE);
            end
            mse_pkg::PH_Q2: begin
                // Literal from low byte, file register from memory
                if (q.kind == mse_pkg::K_MUL_LIT || q.kind == mse_pkg::K_SUB_LIT) begin
                    d.operand = q.instr[7:0];
                end else begin
                    d.operand = mem_rd_ea;
                end
                d.phase = mse_pkg::PH_Q3;
            end
            mse_pkg::PH_Q3: begin
                d.result    = alu_result;
                d.new_flags = alu_flags;
                d.phase     = mse_pkg::PH_Q4;
            end
            mse_pkg::PH_Q4: begin
                // Result lands in its destination
                d.phase = mse_pkg::PH_IDLE;
                if (is_sub) begin
                    d.flags = q.new_flags;
                    if (q.kind == mse_pkg::K_SUB_REG && q.instr[mse_pkg::BIT_DEST]) begin
                        mem_we = 1'b1;
                    end else begin
                        d.acc = q.result[7:0];
                    end
                end else begin
                    d.prod = q.result;
                end
            end
            default: begin
                d.phase = mse_pkg::PH_IDLE;
            end
        endcase

        // APB access phase: answer one cycle after entry
        if (psel && penable && !q.pready) begin
            d.pready  = 1'b1;
            d.pslverr = 1'b0;
            d.prdata  = 32'h0000_0000;
            // Mapped reads always succeed
            unique case (paddr)
                mse_pkg::OFF_INSTR: begin
                    d.prdata[15:0]              = q.instr;
                    d.prdata[mse_pkg::BIT_BUSY] = !idle;
                    d.prdata[mse_pkg::BIT_BAD]  = q.bad;
                    d.pslverr = refuse_wr(pwrite, q.phase);
                end
                mse_pkg::OFF_ACC: begin
                    d.prdata = {24'h000000, q.acc};
                    d.pslverr = refuse_wr(pwrite, q.phase);
                end
                mse_pkg::OFF_BANKSEL: begin
                    d.prdata = {28'h0000000, q.bank};
                    d.pslverr = refuse_wr(pwrite, q.phase);
                end
                mse_pkg::OFF_PROD: begin
                    d.prdata = {16'h0000, q.prod};
                    d.pslverr = refuse_wr(pwrite, q.phase);
                end
                mse_pkg::OFF_FLAGS: begin
                    d.prdata = {27'h0000000, q.flags};
                    d.pslverr = refuse_wr(pwrite, q.phase);
                end
                mse_pkg::OFF_MADDR: begin
                    // Window address may move at any time
                    d.prdata = {20'h00000, q.maddr};
                end
                mse_pkg::OFF_MDATA: begin
                    d.prdata = {24'h000000, mem_rd_sw};
                    d.pslverr = refuse_wr(pwrite, q.phase);
                end
                default: begin
                    d.pslverr = 1'b1;
                end
            endcase
        end

        // Writes take effect on the completing edge
        if (xfer && pwrite && !q.pslverr) begin
            unique case (paddr)
                // New instruction clears the bad mark
                mse_pkg::OFF_INSTR: begin
                    d.instr = pwdata[15:0];
                    d.bad   = 1'b0;
                    d.phase = mse_pkg::PH_Q1;
                end
                mse_pkg::OFF_ACC: begin
                    d.acc = pwdata[7:0];
                end
                mse_pkg::OFF_BANKSEL: begin
                    d.bank = pwdata[3:0];
                end
                mse_pkg::OFF_PROD: begin
                    d.prod = pwdata[15:0];
                end
                mse_pkg::OFF_FLAGS: begin
                    d.flags = pwdata[4:0];
                end
                mse_pkg::OFF_MADDR: begin
                    d.maddr = pwdata[11:0];
                end
                // One byte into memory at the window address
                mse_pkg::OFF_MDATA: begin
                    mem_we = 1'b1;
                    mem_wa = q.maddr;
                    mem_wd = pwdata[7:0];
                end
                default: begin
                end
            endcase
        end

        // Busy level registered so the port comes from a flop
        d.busy = (d.phase != mse_pkg::PH_IDLE);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q           <= '0;
            q.phase     <= mse_pkg::PH_IDLE;
            q.kind      <= mse_pkg::K_NONE;
            q.acc       <= mse_pkg::RST_ACC;
            q.bank      <= mse_pkg::RST_BANK;
            q.prod      <= mse_pkg::RST_PROD;
            q.flags     <= mse_pkg::RST_FLAGS;
            q.busy      <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // Data memory, no reset
    // Bytes stay unknown until software or an instruction writes them
    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // Registered outputs
    assign prdata  = q.prdata;
    assign pready  = q.pready;
    assign pslverr = q.pslverr;
    assign busy    = q.busy;
endmodule

// [tb/mse_exec_props.sv]
// Purpose: Port-level properties of the execution block
// Assumes: One clock, async active-low reset
// Notes:   Sees only the top-level APB and busy ports
`timescale 1ns/10ps
module mse_exec_props (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Execution state
    input wire logic        busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Instruction word that the decoder knows
    logic op_ok;
    assign op_ok = pwdata[15:8] == mse_pkg::OPC_MUL_LIT || pwdata[15:8] == mse_pkg::OPC_SUB_LIT
                || pwdata[15:9] == mse_pkg::OPC_MUL_REG || pwdata[15:10] == mse_pkg::OPC_SUB_REG;
    sequence s_done;
        psel && penable && pready;
    endsequence
    sequence s_go;
        s_done ##0 pwrite && paddr == mse_pkg::OFF_INSTR && !busy;
    endsequence
    property p_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_wait: assert property (p_wait) else $error("pready late");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready not a pulse");
    property p_busy4;
        s_go ##0 op_ok |=> busy [*4] ##1 !busy;
    endproperty
    a_busy4: assert property (p_busy4) else $error("busy not four cycles");
    property p_bad1;
        s_go ##0 !op_ok |=> busy ##1 !busy;
    endproperty
    a_bad1: assert property (p_bad1) else $error("bad opcode busy length");
    property p_cause;
        $rose(busy) |-> $past(psel && penable && pready && pwrite && paddr == mse_pkg::OFF_INSTR);
    endproperty
    a_cause: assert property (p_cause) else $error("busy without instruction");
    property p_refuse;
        s_done ##0 pwrite && busy && paddr != mse_pkg::OFF_MADDR |-> pslverr;
    endproperty
    a_refuse: assert property (p_refuse) else $error("write while busy accepted");
    property p_unmap;
        s_done ##0 paddr > mse_pkg::OFF_MDATA |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
    property p_readok;
        s_done ##0 !pwrite && paddr <= mse_pkg::OFF_MDATA && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    a_readok: assert property (p_readok) else $error("mapped read refused");
endmodule

// [tb/mse_exec_tb.sv]
// Purpose: Self-checking bench for the execution block
// Assumes: APB master with one idle cycle between transfers
// Notes:   Table rows first, then bad opcode, refusal and reset
`timescale 1ns/10ps
module mse_exec_tb;
    typedef struct packed {
        logic [15:0] ins;
        logic [7:0]  acc;
        logic [3:0]  bnk;
        logic [11:0] ma;
        logic [7:0]  mv;
        logic [4:0]  fl;
        logic [7:0]  e_acc;
        logic [15:0] e_prod;
        logic [4:0]  e_fl;
        logic [7:0]  e_mem;
    } mse_row_type;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy;
    logic [31:0] rd;
    logic        err;
    int          num_errors;
    int          num_checks;
    mse_row_type rows [10];

    mse_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
                    .pslverr(pslverr), .busy(busy));

    // Clock at 200 MHz
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Value compare
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer, then one idle edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rd  = prdata;
        err = pslverr;
        if (n >= 100) chk("pready", 32'h1, 32'h0);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, e, rd);
    endtask

    // Issue instruction, wait until idle
    task automatic exec(input logic [15:0] ins);
        int n;
        n = 0;
        apb(1'b1, mse_pkg::OFF_INSTR, {16'h0, ins});
        while (busy !== 1'b0 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) chk("busy", 32'h0, 32'h1);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #100000;
        num_errors++;
        results();
    end

    // Main sequence
    initial begin
        num_errors = 0;
        num_checks = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        rows[0] = '{16'h0DC4, 8'hE2, 4'h0, 12'h000, 8'h5A, 5'h1F, 8'hE2, 16'hAD08, 5'h1F, 8'h5A};
        rows[1] = '{16'h0285, 8'hC4, 4'h3, 12'hF85, 8'hB5, 5'h00, 8'hC4, 16'h8A94, 5'h00, 8'hB5};
        rows[2] = '{16'h0310, 8'h07, 4'h5, 12'h510, 8'h03, 5'h0A, 8'h07, 16'h0015, 5'h0A, 8'h03};
        rows[3] = '{16'h0802, 8'h01, 4'h0, 12'h000, 8'h5A, 5'h1F, 8'h01, 16'h1234, 5'h03, 8'h5A};
        rows[4] = '{16'h0802, 8'h02, 4'h0, 12'h000, 8'h5A, 5'h00, 8'h00, 16'h1234, 5'h07, 8'h5A};
        rows[5] = '{16'h0802, 8'h03, 4'h0, 12'h000, 8'h5A, 5'h0F, 8'hFF, 16'h1234, 5'h10, 8'h5A};
        rows[6] = '{16'h0880, 8'h01, 4'h0, 12'h000, 8'h5A, 5'h00, 8'h7F, 16'h1234, 5'h09, 8'h5A};
        rows[7] = '{16'h5E20, 8'h02, 4'h7, 12'h020, 8'h03, 5'h00, 8'h02, 16'h1234, 5'h03, 8'h01};
        rows[8] = '{16'h5D40, 8'h02, 4'h2, 12'h240, 8'h02, 5'h00, 8'h00, 16'h1234, 5'h07, 8'h02};
        rows[9] = '{16'h5F41, 8'h02, 4'h2, 12'h241, 8'h01, 5'h00, 8'h02, 16'h1234, 5'h10, 8'hFF};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            apb(1'b1, mse_pkg::OFF_ACC, {24'h0, rows[i].acc});
            apb(1'b1, mse_pkg::OFF_BANKSEL, {28'h0, rows[i].bnk});
            apb(1'b1, mse_pkg::OFF_PROD, 32'h0000_1234);
            apb(1'b1, mse_pkg::OFF_FLAGS, {27'h0, rows[i].fl});
            apb(1'b1, mse_pkg::OFF_MADDR, {20'h0, rows[i].ma});
            apb(1'b1, mse_pkg::OFF_MDATA, {24'h0, rows[i].mv});
            exec(rows[i].ins);
            rdc(mse_pkg::OFF_ACC, {24'h0, rows[i].e_acc}, "acc");
            rdc(mse_pkg::OFF_PROD, {16'h0, rows[i].e_prod}, "product");
            rdc(mse_pkg::OFF_FLAGS, {27'h0, rows[i].e_fl}, "flags");
            rdc(mse_pkg::OFF_MDATA, {24'h0, rows[i].e_mem}, "file reg");
            $display("row %0d done", i);
        end
        // Unknown opcode sets bad and leaves acc unchanged
        exec(16'hFFFF);
        rdc(mse_pkg::OFF_INSTR, 32'h0002_FFFF, "bad op");
        rdc(mse_pkg::OFF_ACC, 32'h0000_0002, "acc kept");
        $display("bad opcode done");
        // Write during execution is refused
        apb(1'b1, mse_pkg::OFF_INSTR, 32'h0000_0D03);
        apb(1'b1, mse_pkg::OFF_ACC, 32'h0000_0055);
        chk("busy write", 32'h1, {31'h0, err});
        exec(16'hFFFF);
        rdc(mse_pkg::OFF_PROD, 32'h0000_0006, "product");
        rdc(mse_pkg::OFF_ACC, 32'h0000_0002, "acc");
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        $display("refusals done");
        // Reset in mid-instruction
        apb(1'b1, mse_pkg::OFF_INSTR, 32'h0000_0802);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("busy", 32'h0, {31'h0, busy});
        for (int k = 1; k < 5; k++) rdc(8'(4 * k), 32'h0, "reset value");
        $display("reset done");
        results();
    end
endmodule

bind mse_exec mse_exec_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy));
